// File: hdl/bus_matrix_defs.svh
// Constants of the multilayer bus matrix: register offsets, fields, resets, map.
// Assumes a 32-bit address space and AXI4-Lite byte addressing of registers.
//
// Behaviour
// - Six independent layers; masters on different free slaves transfer concurrently.
// - Each master has its own address decoder; all decoders share one map.
// - Masters: 0 processor, 1 peripheral DMA, 2 to 5 custom masters A-D.
// - Ten slaves, each with its own arbiter and own software arbitration setting.
// - Slaves: SRAM96, SRAM64, ROM, custom A-D, control, external bus, bridge.
// - Slave 7 answers master 0 only; other masters get an abort.
// - Arbiters do fixed priority or round robin; under round robin, default none, last or fixed.
// - Bursts of any length; broken when the programmable slot limit is reached.
// - Boot region selects internal boot, external boot or remapped slave.
// - Boot memory chosen by boot-select pin level sampled during reset.
// - Remap command puts internal SRAM over the boot region.
// - Peripheral DMA is one ordinary master port.
// - Sixteen 256 MB banks: 0 internal, 1-9 external bus, 15 peripherals.
// - Accesses to unused regions end with an abort to the issuing master.
// - Pin low maps address zero to external memory, high to ROM.
`ifndef BUS_MATRIX_DEFS_SVH
`define BUS_MATRIX_DEFS_SVH

`define BM_NM 6
`define BM_NS 10

// Register byte offsets; slave s config at CFG_OFS + 4*s
`define CFG_OFS 8'h00
`define REMAP_OFS 8'h40
`define STAT_OFS 8'h44
`define ISR_OFS 8'h48
`define IMR_OFS 8'h4C

// Config fields
`define CFG_RR_BIT 0
`define CFG_DT_LSB 1
`define CFG_DF_LSB 3
`define CFG_SLOT_LSB 8
`define CFG_MASK 16'hFF3F
`define CFG_RST 16'h0000

// Slave numbers
`define S_SRAM0 4'h0
`define S_SRAM1 4'h1
`define S_ROM 4'h2
`define S_CTRL 4'h7
`define S_EBI 4'h8
`define S_BRIDGE 4'h9

// Banks (256 MB each) and internal regions (1 MB each)
`define BANK_INT 4'h0
`define BANK_EBI_LAST 4'h9
`define BANK_PERIPH 4'hF
`define REG_BOOT 4'h0
`define REG_ROM 4'h1
`define REG_SRAM0 4'h2
`define REG_SRAM1 4'h3
`define REG_CUST_FIRST 4'h4
`define REG_CUST_LAST 4'h7
`define REG_CTRL 4'h8

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hdl/bus_matrix_pkg.sv
// Types shared by the bus matrix.
// Assumes nothing beyond a SystemVerilog compiler.
package bus_matrix_pkg;
  typedef enum logic [1:0] {
    DEF_NONE = 2'h0,
    DEF_LAST = 2'h1,
    DEF_FIXED = 2'h2
  } defm_t;
  typedef logic [3:0] slave_idx_t;
  typedef logic [2:0] master_idx_t;
endpackage

// File: hdl/multilayer_bus_matrix.sv
// Six-master, ten-slave bus matrix with per-slave arbiters and AXI4-Lite registers.
// Assumes masters hold request and payload until done; slaves answer with ready.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`include "bus_matrix_defs.svh"

module multilayer_bus_matrix (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic boot_select_pin,
  input wire logic [5:0] m_req,
  input wire logic [5:0] m_burst,
  input wire logic [5:0] m_write,
  input wire logic [5:0][31:0] m_addr,
  input wire logic [5:0][31:0] m_wdata,
  output logic [5:0] m_done,
  output logic [5:0] m_abort,
  output logic [5:0][31:0] m_rdata,
  output logic [9:0] s_sel,
  output logic [9:0] s_write,
  output logic [9:0][31:0] s_addr,
  output logic [9:0][31:0] s_wdata,
  output logic [9:0][2:0] s_master,
  input wire logic [9:0] s_ready,
  input wire logic [9:0][31:0] s_rdata,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq
);

  logic [15:0] cfg_r [10];
  logic remap_r;
  logic boot_m_r;
  logic boot_s_r;
  logic boot_sel_r;
  logic [5:0] isr_r;
  logic [5:0] imr_r;
  logic [5:0] act_r;
  logic [9:0] hold_r;
  logic [7:0] cnt_r [10];
  logic [4:0] dec [6];
  logic [5:0] reqm [10];
  logic [3:0] win [10];

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Returns {abort, slave}
  function automatic logic [4:0] decode(input logic [31:0] a, input logic m0, input logic remap,
                                        input logic bsel);
    logic [4:0] r;
    r = {1'b1, 4'h0};
    if (a[31:28] == `BANK_INT) begin
      if (a[27:24] == 4'h0) begin
        if (a[23:20] == `REG_BOOT) begin
          if (remap) r = {1'b0, `S_SRAM0};
          else if (bsel) r = {1'b0, `S_ROM};
          else r = {1'b0, `S_EBI};
        end else if (a[23:20] == `REG_ROM) begin
          r = {1'b0, `S_ROM};
        end else if (a[23:20] == `REG_SRAM0) begin
          r = {1'b0, `S_SRAM0};
        end else if (a[23:20] == `REG_SRAM1) begin
          r = {1'b0, `S_SRAM1};
        end else if (a[23:20] >= `REG_CUST_FIRST && a[23:20] <= `REG_CUST_LAST) begin
          r = {1'b0, a[23:20] - 4'h1};
        end else if (a[23:20] == `REG_CTRL && m0) begin
          r = {1'b0, `S_CTRL};
        end
      end
    end else if (a[31:28] <= `BANK_EBI_LAST) begin
      r = {1'b0, `S_EBI};
    end else if (a[31:28] == `BANK_PERIPH) begin
      r = {1'b0, `S_BRIDGE};
    end
    return r;
  endfunction

  // Returns {valid, master}
  function automatic logic [3:0] pick(input logic [5:0] req, input logic [15:0] cfg,
                                      input bus_matrix_pkg::master_idx_t last);
    logic [3:0] r;
    bus_matrix_pkg::master_idx_t k;
    bus_matrix_pkg::master_idx_t df;
    bus_matrix_pkg::defm_t dt;
    r = 4'h0;
    df = cfg[`CFG_DF_LSB +: 3];
    dt = bus_matrix_pkg::defm_t'(cfg[`CFG_DT_LSB +: 2]);
    if (!cfg[`CFG_RR_BIT]) begin
      for (int i = 5; i >= 0; i--) begin
        if (req[i]) r = {1'b1, 3'(i)};
      end
    end else begin
      for (int i = 5; i >= 0; i--) begin
        k = 3'((int'(last) + 1 + i) % 6);
        if (req[k]) r = {1'b1, k};
      end
      if (dt == bus_matrix_pkg::DEF_LAST && req[last]) r = {1'b1, last};
      if (dt == bus_matrix_pkg::DEF_FIXED && df < 3'h6 && req[df]) r = {1'b1, df};
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode and arbitration

  always_comb begin
    for (int m = 0; m < 6; m++) begin
      dec[m] = decode(m_addr[m], m == 0, remap_r, boot_sel_r);
    end
    for (int s = 0; s < 10; s++) begin
      reqm[s] = 6'h00;
      for (int m = 0; m < 6; m++) begin
        reqm[s][m] = m_req[m] & ~m_done[m] & ~act_r[m] & ~dec[m][4] & (dec[m][3:0] == 4'(s));
      end
      if (hold_r[s]) reqm[s] = reqm[s] & (6'h01 << s_master[s]);
      win[s] = pick(reqm[s], cfg_r[s], s_master[s]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_sel <= 10'h000;
      s_write <= 10'h000;
      s_addr <= '0;
      s_wdata <= '0;
      s_master <= '0;
      hold_r <= 10'h000;
      for (int s = 0; s < 10; s++) cnt_r[s] <= 8'h00;
      act_r <= 6'h00;
      m_done <= 6'h00;
      m_abort <= 6'h00;
      m_rdata <= '0;
    end else if (ce) begin
      m_done <= 6'h00;
      m_abort <= 6'h00;
      for (int m = 0; m < 6; m++) begin
        if (m_req[m] && !m_done[m] && !act_r[m] && dec[m][4]) begin
          m_done[m] <= 1'b1;
          m_abort[m] <= 1'b1;
        end
      end
      for (int s = 0; s < 10; s++) begin
        if (s_sel[s]) begin
          if (s_ready[s]) begin
            s_sel[s] <= 1'b0;
            act_r[s_master[s]] <= 1'b0;
            m_done[s_master[s]] <= 1'b1;
            m_rdata[s_master[s]] <= s_rdata[s];
            if (m_burst[s_master[s]] &&
                (cfg_r[s][`CFG_SLOT_LSB +: 8] == 8'h00 ||
                 cnt_r[s] + 8'h01 < cfg_r[s][`CFG_SLOT_LSB +: 8])) begin
              hold_r[s] <= 1'b1;
              cnt_r[s] <= cnt_r[s] + 8'h01;
            end else begin
              hold_r[s] <= 1'b0;
              cnt_r[s] <= 8'h00;
            end
          end
        end else if (win[s][3]) begin
          s_sel[s] <= 1'b1;
          s_master[s] <= win[s][2:0];
          s_addr[s] <= m_addr[win[s][2:0]];
          s_write[s] <= m_write[win[s][2:0]];
          s_wdata[s] <= m_wdata[win[s][2:0]];
          act_r[win[s][2:0]] <= 1'b1;
        end else if (hold_r[s] && !m_burst[s_master[s]]) begin
          hold_r[s] <= 1'b0;
          cnt_r[s] <= 8'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot select sampling

  always_ff @(posedge aclk) begin
    if (ce) begin
      boot_m_r <= boot_select_pin;
      boot_s_r <= boot_m_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn && ce) boot_sel_r <= boot_s_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write

  logic [7:0] wa;
  assign wa = awaddr[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (ce) begin
      awready <= 1'b0;
      wready <= 1'b0;
      if (awvalid && wvalid && !awready && !bvalid) begin
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (awready) begin
        bvalid <= 1'b1;
        bresp <= (wa <= `IMR_OFS && wa[1:0] == 2'b00) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int s = 0; s < 10; s++) cfg_r[s] <= `CFG_RST;
      remap_r <= 1'b0;
      imr_r <= 6'h00;
    end else if (ce && awready) begin
      for (int s = 0; s < 10; s++) begin
        if (wa == `CFG_OFS + 8'(4 * s)) begin
          cfg_r[s] <= 16'(merge({16'h0000, cfg_r[s]}, wdata, wstrb)) & `CFG_MASK;
        end
      end
      if (wa == `REMAP_OFS && wstrb[0]) remap_r <= wdata[0];
      if (wa == `IMR_OFS) imr_r <= 6'(merge({26'h0, imr_r}, wdata, wstrb));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      isr_r <= 6'h00;
      irq <= 1'b0;
    end else if (ce) begin
      if (awready && wa == `ISR_OFS && wstrb[0]) isr_r <= (isr_r & ~wdata[5:0]) | m_abort;
      else isr_r <= isr_r | m_abort;
      irq <= |(isr_r & imr_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read

  logic [31:0] rd_nxt;
  logic rd_ok;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_ok = araddr[1:0] == 2'b00;
    if (araddr[7:0] < `REMAP_OFS) begin
      rd_ok = rd_ok && araddr[7:2] < 6'd10;
      for (int s = 0; s < 10; s++) begin
        if (araddr[7:0] == `CFG_OFS + 8'(4 * s)) rd_nxt = {16'h0000, cfg_r[s]};
      end
    end else if (araddr[7:0] == `REMAP_OFS) rd_nxt = {31'h0, remap_r};
    else if (araddr[7:0] == `STAT_OFS) rd_nxt = {30'h0, remap_r, boot_sel_r};
    else if (araddr[7:0] == `ISR_OFS) rd_nxt = {26'h0, isr_r};
    else if (araddr[7:0] == `IMR_OFS) rd_nxt = {26'h0, imr_r};
    else rd_ok = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (ce) begin
      arready <= arvalid && !arready && !rvalid;
      if (arready) begin
        rvalid <= 1'b1;
        rdata <= rd_ok ? rd_nxt : 32'h0000_0000;
        rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule // multilayer_bus_matrix

// File: bench/bus_matrix_props.sv
// Port checker of the bus matrix.
// Assumes binding to multilayer_bus_matrix with ce held high.
module bus_matrix_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] m_req,
  input wire logic [5:0][31:0] m_addr,
  input wire logic [5:0] m_done,
  input wire logic [5:0] m_abort,
  input wire logic [9:0] s_sel,
  input wire logic [9:0] s_ready,
  input wire logic [9:0][2:0] s_master,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  a_abort_done: assert property (|m_abort |-> (m_abort & ~m_done) == 6'h00)
    else $error("abort without done");
  a_ctrl_owner: assert property (s_sel[7] |-> s_master[7] == 3'h0)
    else $error("control slave owned by other master");
  a_ctrl_abort: assert property (m_req[2] && !m_done[2] && m_addr[2][31:20] == 12'h008 |=> m_abort[2])
    else $error("control access not aborted");
  a_sel_holds: assert property ((s_sel & ~s_ready) != 10'h000 |=> ($past(s_sel & ~s_ready) & ~s_sel) == 10'h000)
    else $error("select dropped early");
  a_done_after: assert property (s_sel[0] && s_ready[0] |=> m_done[$past(s_master[0])])
    else $error("done late");
  a_done_pulse: assert property (|m_done |=> (m_done & $past(m_done)) == 6'h00)
    else $error("done too long");
  a_write_resp: assert property (awready |-> wready ##1 bvalid)
    else $error("write answer late");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("response dropped");
  c_abort: cover property (m_abort[2]);
  c_ebi: cover property (s_sel[8] && s_ready[8]);
  c_irq: cover property (irq);
endmodule // bus_matrix_props

bind multilayer_bus_matrix bus_matrix_props props_inst (.aclk, .aresetn, .m_req, .m_addr, .m_done, .m_abort,
  .s_sel, .s_ready, .s_master, .awready, .wready, .bvalid, .bready, .bresp, .irq);

// File: bench/slave_model.sv
// Behavioural model of the ten slaves behind the matrix.
// Assumes select and address stay steady until ready is taken.
module slave_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] wait_n,
  input wire logic [9:0] s_sel,
  input wire logic [9:0][31:0] s_addr,
  output logic [9:0] s_ready,
  output logic [9:0][31:0] s_rdata
);
  logic [9:0][1:0] cnt_r;
  always_ff @(posedge aclk) begin
    for (int k = 0; k < 10; k++) begin
      if (!aresetn) begin
        cnt_r[k] <= 2'h0;
        s_ready[k] <= 1'h0;
        s_rdata[k] <= 32'h5A5A5A5A;
      end else begin
        cnt_r[k] <= (s_sel[k] && !s_ready[k]) ? cnt_r[k] + 2'h1 : 2'h0;
        s_ready[k] <= s_sel[k] && !s_ready[k] && cnt_r[k] == wait_n;
        // Slave number in top nibble; junk while idle
        s_rdata[k] <= (s_sel[k] && !s_ready[k] && cnt_r[k] == wait_n) ? {k[3:0], s_addr[k][27:0]} : ~s_rdata[k];
      end
    end
  end
endmodule // slave_model

// File: bench/testbench.sv
// Bench of the bus matrix: map, boot, remap, arbitration, registers, interrupt.
// Assumes the checker binds itself and slave_model answers the slaves.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, boot_select_pin = 1;
  logic [5:0] m_req = '0, m_write = '0, m_burst = '0, m_done, m_abort;
  logic [5:0][31:0] m_addr = '0, m_wdata = '0, m_rdata;
  logic [9:0] s_sel, s_write, s_ready;
  logic [9:0][31:0] s_addr, s_wdata, s_rdata;
  logic [9:0][2:0] s_master;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, slow = '0;
  int num_errors = 0, num_checks = 0, cyc = 0;
  int t_done [6];
  logic [31:0] amap [10] = '{32'h00100000, 32'h00200000, 32'h00300000, 32'h00400000, 32'h00700000,
    32'h10000000, 32'h9FFFFFFC, 32'hF0000000, 32'hA0000000, 32'h00900000};
  logic [3:0] smap [10] = '{4'h2, 4'h0, 4'h1, 4'h3, 4'h6, 4'h8, 4'h8, 4'h9, 4'hF, 4'hF};

  multilayer_bus_matrix multilayer_bus_matrix_inst (.ce(1'h1), .awprot(3'h0), .arprot(3'h0), .wstrb(4'hF), .*);
  slave_model slave_model_inst (.wait_n(slow), .*);

  always #20 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic rst(input logic pin);
    aresetn <= 1'h0;
    boot_select_pin <= pin;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    check(bresp, er);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    check(rdata, exp);
    check(rresp, er);
  endtask

  task automatic xfer(input int m, input logic [31:0] a, input logic [3:0] slv, input logic ab);
    @(posedge aclk);
    m_addr[m] <= a;
    m_wdata[m] <= ~a;
    m_write[m] <= a[2];
    m_req[m] <= 1'h1;
    do @(posedge aclk); while (!m_done[m]);
    m_req[m] <= 1'h0;
    t_done[m] = cyc;
    check(m_abort[m], ab);
    if (!ab && !a[2]) check(m_rdata[m], {slv, a[27:0]});
    if (!ab) check(s_write[slv], a[2]);
    if (!ab && a[2]) check(s_wdata[slv], ~a);
  endtask

  task automatic race(input logic [31:0] cfg, input int ma, input int mb, input logic [2:0] win);
    axw(8'h00, cfg, 2'h0);
    fork
      xfer(ma, 32'h00200010, 4'h0, 1'h0);
      xfer(mb, 32'h00200010, 4'h0, 1'h0);
      begin
        do @(posedge aclk); while (!s_sel[0]);
        check(s_master[0], win);
      end
    join
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst(1'h1);
    axr(8'h44, 32'h1, 2'h0);
    axr(8'h0C, 32'h0, 2'h0);
    axw(8'h0C, 32'hFFFF, 2'h0);
    axr(8'h0C, 32'hFF3F, 2'h0);
    for (int d = 0; d < 3; d++) begin
      axw(8'h10, 32'(d * 2), 2'h0);
      axr(8'h10, 32'(d * 2), 2'h0);
    end
    axr(8'h50, 32'h0, 2'h2);
    axw(8'h50, 32'h1, 2'h2);
    slow <= 2'h2;
    for (int i = 0; i < 10; i++) xfer(i % 6, amap[i], smap[i], smap[i] == 4'hF);
    slow <= 2'h0;
    xfer(0, 32'h0, 4'h2, 1'h0);
    xfer(0, 32'h00800000, 4'h7, 1'h0);
    xfer(2, 32'h00800000, 4'h0, 1'h1);
    axr(8'h48, 32'hC, 2'h0);
    check(irq, 1'h0);
    axw(8'h4C, 32'h4, 2'h0);
    repeat (2) @(posedge aclk);
    check(irq, 1'h1);
    axw(8'h48, 32'h4, 2'h0);
    axr(8'h48, 32'h8, 2'h0);
    check(irq, 1'h0);
    axw(8'h40, 32'h1, 2'h0);
    axr(8'h44, 32'h3, 2'h0);
    xfer(0, 32'h0, 4'h0, 1'h0);
    fork
      xfer(0, 32'h00200000, 4'h0, 1'h0);
      xfer(5, 32'hF0000000, 4'h9, 1'h0);
    join
    check(t_done[0], t_done[5]);
    race(32'h0, 1, 4, 3'h1);
    race(32'h1, 4, 5, 3'h5);
    race(32'h15, 2, 5, 3'h2);
    race(32'h3, 0, 5, 3'h5);
    // Slot limit of two beats on slave 1 breaks master 3 burst
    axw(8'h04, 32'h0200, 2'h0);
    m_burst[3] <= 1'h1;
    fork
      begin
        xfer(3, 32'h00300000, 4'h1, 1'h0);
        xfer(3, 32'h00300004, 4'h1, 1'h0);
        check(m_req[2], 1'h1);
        xfer(3, 32'h00300008, 4'h1, 1'h0);
      end
      begin
        @(posedge aclk);
        xfer(2, 32'h00300000, 4'h1, 1'h0);
      end
    join
    m_burst[3] <= 1'h0;
    check(32'(t_done[2] < t_done[3]), 32'h1);
    rst(1'h0);
    axr(8'h44, 32'h0, 2'h0);
    xfer(1, 32'h0, 4'h8, 1'h0);
    results();
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
endmodule // testbench
